// ### rtl/fpm_pkg.sv
package fpm_pkg;

  // ************************************************************
  // Key codes
  // ************************************************************
  localparam logic [7:0] FPM_KEY_DOWNLOAD = 8'hA5;
  localparam logic [7:0] FPM_KEY_PROGRAM  = 8'h5A;
  localparam logic [7:0] FPM_KEY_RESET    = 8'h00;

  // ************************************************************
  // Array layout
  // ************************************************************
  localparam int          FPM_ADDR_W      = 17;
  localparam logic [16:0] FPM_BOOT_SPAN   = 17'h02000;
  localparam logic        FPM_SEL_USER    = 1'b0;
  localparam logic        FPM_SEL_RESET   = 1'b0;

  // ************************************************************
  // Reset hold time
  // ************************************************************
  localparam int FPM_CLK_MHZ          = 250;
  localparam int FPM_RESET_HOLD_US    = 100;
  localparam int FPM_RESET_HOLD_CYC   = FPM_RESET_HOLD_US * FPM_CLK_MHZ;

  // ************************************************************
  // Result codes
  // ************************************************************
  localparam logic [1:0] FPM_RES_OK       = 2'h0;
  localparam logic [1:0] FPM_RES_PROTECT  = 2'h1;
  localparam logic [1:0] FPM_RES_ERROR    = 2'h2;

  // ************************************************************
  // Bundles
  // ************************************************************
  typedef struct packed {
    logic irq;
    logic nmi;
    logic flash_read;
    logic sleep;
  } fpm_event_t;

  typedef struct packed {
    logic                  valid;
    logic [FPM_ADDR_W-1:0] addr;
  } fpm_access_t;

endpackage

// ### rtl/fpm_flash_protect.sv
`timescale 1ns/1ps
module fpm_flash_protect (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Software control and hardware protect input
  input  wire logic                        key_wr,
  input  wire logic [7:0]                  key_wdata,
  input  wire logic                        download_req_wr,
  input  wire logic                        download_req_wdata,
  input  wire logic                        select_wr,
  input  wire logic                        select_wdata,
  input  wire logic                        hw_protect,
  // Operation requests
  input  wire logic                        download_start,
  input  wire logic                        op_start,
  input  wire logic                        op_done,
  // Events during operation
  input  wire fpm_pkg::fpm_event_t         events,
  input  wire fpm_pkg::fpm_access_t        access,
  // Status
  output logic [7:0]                       flash_key_reg,
  output logic                             download_request_bit,
  output logic                             array_select_reg,
  output logic                             flash_error_flag,
  output logic                             download_grant,
  output logic                             op_active,
  output logic                             op_abort,
  output logic [1:0]                       op_result_param,
  output logic                             boot_array_sel,
  output logic                             user_array_sel,
  output logic                             access_undefined
);
  import fpm_pkg::*;

  typedef enum logic [1:0] {FPM_IDLE, FPM_BUSY, FPM_ERROR} fpm_state_t;

  fpm_state_t state;
  fpm_state_t next_state;
  logic       error_event;
  logic       program_allowed;
  logic       download_allowed;
  logic       op_accept;
  logic       op_refuse;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic user_selected(input logic sel);
    return sel == FPM_SEL_USER;
  endfunction

  function automatic logic key_matches(input logic [7:0] key, input logic [7:0] code);
    return key == code;
  endfunction

  // ************************************************************
  // Permission decode
  // ************************************************************
  assign download_allowed = download_request_bit &&
                            key_matches(flash_key_reg, FPM_KEY_DOWNLOAD);
  assign program_allowed  = !hw_protect &&
                            key_matches(flash_key_reg, FPM_KEY_PROGRAM) &&
                            user_selected(array_select_reg) &&
                            !flash_error_flag;
  assign op_accept        = (state == FPM_IDLE) && op_start && program_allowed;
  assign op_refuse        = (state == FPM_IDLE) && op_start && !program_allowed;
  assign error_event = (state == FPM_BUSY) &&
                       (events.irq || events.nmi ||
                        events.flash_read || access.valid ||
                        events.sleep);

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_key_reg        <= FPM_KEY_RESET;
      download_request_bit <= 1'b0;
      array_select_reg     <= FPM_SEL_RESET;
    end else begin
      if (key_wr) begin
        flash_key_reg <= key_wdata;
      end
      if (download_req_wr) begin
        download_request_bit <= download_req_wdata;
      end
      if (select_wr) begin
        array_select_reg <= select_wdata;
      end
    end
  end

  // ************************************************************
  // Operation and error protection
  // ************************************************************
  always_comb begin
    next_state = state;
    case (state)
      FPM_IDLE: begin
        if (op_accept) begin
          next_state = FPM_BUSY;
        end
      end
      FPM_BUSY: begin
        if (error_event) begin
          next_state = FPM_ERROR;
        end else if (op_done) begin
          next_state = FPM_IDLE;
        end
      end
      FPM_ERROR: begin
        next_state = FPM_ERROR;
      end
      default: begin
        next_state = FPM_ERROR;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= FPM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Sticky error flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_error_flag <= 1'b0;
    end else if (error_event) begin
      flash_error_flag <= 1'b1;
    end
  end

  // Operation running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_active <= 1'b0;
    end else if (op_accept) begin
      op_active <= 1'b1;
    end else if (error_event || ((state == FPM_BUSY) && op_done)) begin
      op_active <= 1'b0;
    end
  end

  // Abort pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_abort <= 1'b0;
    end else begin
      op_abort <= error_event;
    end
  end

  // Result code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_result_param <= FPM_RES_OK;
    end else if (op_accept) begin
      op_result_param <= FPM_RES_OK;
    end else if (op_refuse) begin
      op_result_param <= FPM_RES_PROTECT;
    end else if (error_event) begin
      op_result_param <= FPM_RES_ERROR;
    end else if ((state == FPM_ERROR) && op_start) begin
      op_result_param <= FPM_RES_ERROR;
    end
  end

  // Download grant pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      download_grant <= 1'b0;
    end else begin
      download_grant <= download_start && download_allowed && !flash_error_flag;
    end
  end

  // ************************************************************
  // Array decode on every valid access
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_array_sel   <= 1'b0;
      user_array_sel   <= 1'b0;
      access_undefined <= 1'b0;
    end else begin
      boot_array_sel   <= access.valid && !user_selected(array_select_reg);
      user_array_sel   <= access.valid && user_selected(array_select_reg);
      access_undefined <= access.valid && !user_selected(array_select_reg) &&
                          (access.addr >= FPM_BOOT_SPAN);
    end
  end

endmodule

// ### sim/fpm_flash_protect_properties.sv
`timescale 1ns/1ps
module fpm_flash_protect_properties
  import fpm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Requests
  input wire logic        download_start,
  input wire logic        op_start,
  input wire logic        hw_protect,
  input wire fpm_event_t  events,
  input wire fpm_access_t access,
  // Status
  input wire logic [7:0]  flash_key_reg,
  input wire logic        download_request_bit,
  input wire logic        array_select_reg,
  input wire logic        flash_error_flag,
  input wire logic        download_grant,
  input wire logic        op_active,
  input wire logic        op_abort,
  input wire logic [1:0]  op_result_param,
  input wire logic        boot_array_sel,
  input wire logic        access_undefined
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fault; op_active && (|events || access.valid); endsequence
  sequence s_abort; op_abort && flash_error_flag && !op_active ##1 !op_abort; endsequence
  chk_fault_abort: assert property (s_fault |=> s_abort)
    else $error("no abort after fault");
  chk_grant_given: assert property (
    download_start && download_request_bit &&
    flash_key_reg == FPM_KEY_DOWNLOAD && !flash_error_flag |=> download_grant)
    else $error("grant missing");
  chk_grant_denied: assert property (
    download_start && (!download_request_bit ||
    flash_key_reg != FPM_KEY_DOWNLOAD) |=> !download_grant)
    else $error("grant without key or bit");
  chk_op_refused: assert property (
    op_start && !op_active && (hw_protect || array_select_reg ||
    flash_key_reg != FPM_KEY_PROGRAM) |=> !op_active && op_result_param != FPM_RES_OK)
    else $error("operation not refused");
  chk_flag_sticky: assert property (flash_error_flag |=> flash_error_flag)
    else $error("error flag dropped");
  chk_error_blocks: assert property (flash_error_flag && op_start |=> !op_active [*2])
    else $error("operation ran in error state");
  chk_boot_span: assert property (
    access.valid && array_select_reg && access.addr >= FPM_BOOT_SPAN |=> access_undefined)
    else $error("boot overrun not flagged");
  chk_array_route: assert property (access.valid |=> boot_array_sel == $past(array_select_reg))
    else $error("wrong array selected");
endmodule

// ### sim/fpm_cpu_model.sv
`timescale 1ns/1ps
module fpm_cpu_model
  import fpm_pkg::*;
(
  // Scenario select
  input wire logic [2:0]  kind,
  input wire logic [16:0] addr,
  // Toward the block
  output fpm_event_t      events,
  output fpm_access_t     access
);
  assign events = {kind == 3'h1, kind == 3'h2, kind == 3'h3, kind == 3'h4};
  assign access.valid = kind == 3'h5;
  assign access.addr = access.valid ? addr : ~addr;
endmodule

// ### sim/flash_protect_mat_switch_tb.sv
`timescale 1ns/1ps
module flash_protect_mat_switch_tb;
  import fpm_pkg::*;
  logic clk, resetn, key_wr, download_req_wr, download_req_wdata, select_wr, select_wdata;
  logic hw_protect, download_start, op_start, op_done, access_undefined, err;
  logic download_request_bit, array_select_reg, flash_error_flag, download_grant;
  logic op_active, op_abort, boot_array_sel, user_array_sel;
  logic [7:0] key_wdata, flash_key_reg;
  logic [1:0] op_result_param, res;
  logic [2:0] kind;
  logic [16:0] addr;
  logic [6:0] q[$];
  fpm_event_t events;
  fpm_access_t access;
  int miscompares, checks_done;
  logic [11:0] sel_seen;
  assign sel_seen = {flash_key_reg, download_request_bit, boot_array_sel, user_array_sel,
                     access_undefined};
  fpm_flash_protect dut (
    .clk(clk), .resetn(resetn), .key_wr(key_wr), .key_wdata(key_wdata),
    .download_req_wr(download_req_wr), .download_req_wdata(download_req_wdata),
    .select_wr(select_wr), .select_wdata(select_wdata), .hw_protect(hw_protect),
    .download_start(download_start), .op_start(op_start), .op_done(op_done),
    .events(events), .access(access), .flash_key_reg(flash_key_reg),
    .download_request_bit(download_request_bit), .array_select_reg(array_select_reg),
    .flash_error_flag(flash_error_flag), .download_grant(download_grant),
    .op_active(op_active), .op_abort(op_abort), .op_result_param(op_result_param),
    .boot_array_sel(boot_array_sel), .user_array_sel(user_array_sel),
    .access_undefined(access_undefined));
  fpm_cpu_model cpu (.kind(kind), .addr(addr), .events(events), .access(access));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) begin
    #1;
    if (q.size() > 0) chk({download_grant, op_abort, flash_error_flag, op_active,
      op_result_param, array_select_reg}, q.pop_front());
  end
  task automatic do_reset;
    resetn = 0; err = 0; res = 0;
    repeat (3) @(negedge clk);
    resetn = 1;
    q.push_back(7'h00);
    @(negedge clk);
  endtask
  task automatic go(input logic [7:0] k, input logic d, hw, sel, input logic [2:0] kd);
    logic ok, g;
    logic [11:0] exp_sel;
    key_wr = 1; key_wdata = k; download_req_wr = 1; download_req_wdata = d;
    select_wr = 1; select_wdata = sel; hw_protect = hw;
    @(negedge clk);
    {key_wr, download_req_wr, select_wr} = 3'h0; download_start = 1;
    g = d && k == FPM_KEY_DOWNLOAD && !err;
    ok = k == FPM_KEY_PROGRAM && !hw && !sel && !err;
    @(negedge clk);
    q.push_back({g, 1'b0, err, 1'b0, res, sel});
    download_start = 0; op_start = 1;
    @(negedge clk);
    res = ok ? FPM_RES_OK : (err ? FPM_RES_ERROR : FPM_RES_PROTECT);
    q.push_back({2'h0, err, ok, res, sel});
    op_start = 0; kind = kd;
    @(negedge clk);
    if (ok && kd != 0) begin
      err = 1; res = FPM_RES_ERROR;
    end
    q.push_back({1'b0, ok && kd != 0, err, ok && kd == 0, res, sel});
    kind = 0; op_done = ok && kd == 0;
    @(negedge clk);
    q.push_back({2'h0, err, 1'b0, res, sel});
    op_done = 0; kind = 5; addr = 17'($urandom);
    @(negedge clk);
    exp_sel = {k, d, sel, !sel, sel && addr >= FPM_BOOT_SPAN};
    chk(sel_seen, exp_sel);
    kind = 0;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    {resetn, key_wr, download_req_wr, download_req_wdata, select_wr, select_wdata} = 6'h00;
    {hw_protect, download_start, op_start, op_done, kind, addr, key_wdata} = 0;
    miscompares = 0; checks_done = 0;
    void'($urandom(77859));
    do_reset;
    go(FPM_KEY_DOWNLOAD, 1, 0, 0, 0);
    go(FPM_KEY_DOWNLOAD, 0, 0, 0, 0);
    go(FPM_KEY_PROGRAM, 1, 0, 0, 0);
    go(FPM_KEY_PROGRAM, 1, 1, 0, 0);
    go(FPM_KEY_PROGRAM, 1, 0, 1, 1);
    for (int i = 1; i < 6; i++) begin
      do_reset;
      go(FPM_KEY_PROGRAM, 1, 0, 0, i[2:0]);
      go(FPM_KEY_DOWNLOAD, 1, 0, 0, 0);
    end
    do_reset;
    key_wr = 1; key_wdata = FPM_KEY_PROGRAM;
    @(negedge clk);
    key_wr = 0; op_start = 1;
    @(negedge clk);
    op_start = 0; q.push_back(7'h08);
    @(negedge clk);
    do_reset;
    go(FPM_KEY_PROGRAM, 1, 0, 0, 0);
    final_report;
  end
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
endmodule
bind fpm_flash_protect fpm_flash_protect_properties chk (
  .clk(clk), .resetn(resetn), .download_start(download_start), .op_start(op_start),
  .hw_protect(hw_protect), .events(events), .access(access), .flash_key_reg(flash_key_reg),
  .download_request_bit(download_request_bit), .array_select_reg(array_select_reg),
  .flash_error_flag(flash_error_flag), .download_grant(download_grant),
  .op_active(op_active), .op_abort(op_abort), .op_result_param(op_result_param),
  .boot_array_sel(boot_array_sel), .access_undefined(access_undefined));
